// ==== oed_output_enable_delay_timer.sv ====
`timescale 1ns/1ps
// Functional notes
// - Control register at pointer 7, read/write
// - Valid write loads delay; nonzero delay holds converter off
// - Delay counts down per tick, then enables
// - Delay scales with count times tick period
// - Nonzero on count enables output, zero disables
// - On count decrements per tick, then output off
// - Output timeout equals count times tick period
// - Timeout shutoff starts a one-second timer
// - Addressing within each second keeps output off
// - Fault status at pointer 8, read-only, live
// - Fault bit is one while fault present
// - Fault bits 8..0 map to fixed comparators
module oed_output_enable_delay_timer #(
	parameter int unsigned TICK_CYCLES = oed_pkg::TICK_CYCLES_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_pointer,
	input wire logic reg_write,
	input wire logic [15:0] reg_write_data,
	output logic [15:0] reg_read_data,
	input wire logic link_addressed,
	input wire logic front_amp_sat_high,
	input wire logic front_amp_sat_low,
	input wire logic second_amp_sat_high,
	input wire logic second_amp_sat_low,
	input wire logic output_amp_common_mode,
	input wire logic neg_input_high,
	input wire logic neg_input_low,
	input wire logic pos_input_high,
	input wire logic pos_input_low,
	output logic converter_enable,
	output logic output_enable
);
	typedef struct packed {
		logic [15:0] control;
		logic [oed_pkg::DELAY_WIDTH-1:0] converter_start_delay_count;
		logic [oed_pkg::ON_COUNT_WIDTH-1:0] output_on_count;
		logic conv_en;
		logic out_on;
		logic [15:0] read_data;
	} oed_state_type;

	oed_state_type state;
	oed_state_type next_state;
	oed_timer_if tif();
	logic ctrl_write;
	logic [oed_pkg::FAULT_WIDTH-1:0] fault_flags;
	logic [oed_pkg::DELAY_WIDTH-1:0] wr_delay;
	logic [oed_pkg::ON_COUNT_WIDTH-1:0] wr_on;
	logic tick_now;
	logic delay_done;
	logic on_done;

	// Writes to the status pointer fall through here; the status word has no storage.
	function automatic logic is_control_write(
		input logic [4:0] pointer,
		input logic write
	);
		return write && (pointer == oed_pkg::PTR_OUTPUT_ENABLE_COUNTER_CONTROL);
	endfunction : is_control_write

	function automatic logic [oed_pkg::DELAY_WIDTH-1:0] delay_field(
		input logic [15:0] word
	);
		return word[oed_pkg::DELAY_LSB +: oed_pkg::DELAY_WIDTH];
	endfunction : delay_field

	function automatic logic [oed_pkg::ON_COUNT_WIDTH-1:0] on_field(
		input logic [15:0] word
	);
		return word[oed_pkg::ON_COUNT_LSB +: oed_pkg::ON_COUNT_WIDTH];
	endfunction : on_field

	// One countdown step; a counter parked at zero stays there until the next write.
	function automatic logic [oed_pkg::DELAY_WIDTH-1:0] delay_step(
		input logic [oed_pkg::DELAY_WIDTH-1:0] count,
		input logic tick
	);
		logic [oed_pkg::DELAY_WIDTH-1:0] result;
		result = count;
		if (tick && count != 4'h0) begin
			result = count - 4'h1;
		end
		return result;
	endfunction : delay_step

	function automatic logic [oed_pkg::ON_COUNT_WIDTH-1:0] on_step(
		input logic [oed_pkg::ON_COUNT_WIDTH-1:0] count,
		input logic tick
	);
		logic [oed_pkg::ON_COUNT_WIDTH-1:0] result;
		result = count;
		if (tick && count != 8'h00) begin
			result = count - 8'h01;
		end
		return result;
	endfunction : on_step

	// True on the tick that lets a count of one run out.
	function automatic logic delay_last(
		input logic [oed_pkg::DELAY_WIDTH-1:0] count,
		input logic tick
	);
		return tick && (count == 4'h1);
	endfunction : delay_last

	function automatic logic on_last(
		input logic [oed_pkg::ON_COUNT_WIDTH-1:0] count,
		input logic tick
	);
		return tick && (count == 8'h01);
	endfunction : on_last

	// Unmapped pointers read as zero so a stray read never shows stale data.
	function automatic logic [15:0] read_word(
		input logic [4:0] pointer,
		input logic [15:0] control,
		input logic [oed_pkg::FAULT_WIDTH-1:0] faults
	);
		logic [15:0] result;
		unique case (pointer)
			oed_pkg::PTR_OUTPUT_ENABLE_COUNTER_CONTROL: begin
				result = control;
			end

			oed_pkg::PTR_FAULT_ALARM_STATUS: begin
				result = {7'h00, faults};
			end

			default: begin
				result = 16'h0000;
			end
		endcase
		return result;
	endfunction : read_word

	oed_tick_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tif(tif.timer)
	);

	assign fault_flags[8] = front_amp_sat_high;
	assign fault_flags[7] = front_amp_sat_low;
	assign fault_flags[6] = second_amp_sat_high;
	assign fault_flags[5] = second_amp_sat_low;
	assign fault_flags[4] = output_amp_common_mode;
	assign fault_flags[3] = neg_input_high;
	assign fault_flags[2] = neg_input_low;
	assign fault_flags[1] = pos_input_high;
	assign fault_flags[0] = pos_input_low;

	assign ctrl_write = is_control_write(reg_pointer, reg_write);
	assign wr_delay = delay_field(reg_write_data);
	assign wr_on = on_field(reg_write_data);
	assign tick_now = tif.tick;
	assign delay_done = delay_last(state.converter_start_delay_count, tick_now);
	assign on_done = on_last(state.output_on_count, tick_now);

	assign tif.restart = ctrl_write;
	// Shutoff happens on the tick that takes the on count from one to zero.
	assign tif.wd_start = !ctrl_write && on_done && state.out_on;
	assign tif.wd_kick = link_addressed;

	always_comb begin
		next_state = state;
		if (ctrl_write) begin
			next_state.control = reg_write_data;
			next_state.converter_start_delay_count = wr_delay;
			next_state.conv_en = (wr_delay == 4'h0);
			next_state.output_on_count = wr_on;
			next_state.out_on = (wr_on != 8'h00);
		end else begin
			next_state.converter_start_delay_count =
				delay_step(state.converter_start_delay_count, tick_now);
			if (delay_done) begin
				next_state.conv_en = 1'b1;
			end

			next_state.output_on_count = on_step(state.output_on_count, tick_now);
			if (on_done) begin
				next_state.out_on = 1'b0;
			end

			// Silence on the link for a full second hands the pin back to the output.
			if (tif.wd_expired) begin
				next_state.out_on = 1'b1;
			end
		end
		next_state.read_data = read_word(reg_pointer, state.control, fault_flags);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state.control <= oed_pkg::CONTROL_RESET;
			state.converter_start_delay_count <= 4'h0;
			state.output_on_count <= 8'h00;
			state.conv_en <= 1'b1;
			state.out_on <= 1'b0;
			state.read_data <= 16'h0000;
		end else begin
			state <= next_state;
		end
	end

	assign reg_read_data = state.read_data;
	assign converter_enable = state.conv_en;
	assign output_enable = state.out_on;
endmodule : oed_output_enable_delay_timer

// ==== oed_pkg.sv ====
package oed_pkg;
	localparam logic [4:0] PTR_OUTPUT_ENABLE_COUNTER_CONTROL = 5'h07;
	localparam logic [4:0] PTR_FAULT_ALARM_STATUS = 5'h08;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam int DELAY_LSB = 8;
	localparam int DELAY_WIDTH = 4;
	localparam int ON_COUNT_LSB = 0;
	localparam int ON_COUNT_WIDTH = 8;
	localparam int FAULT_WIDTH = 9;
	localparam int CLK_KHZ = 200000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES_DEFAULT = CLK_KHZ * TICK_MS;
	localparam int COUNT_STEP_MS = 14;
	localparam int WATCHDOG_MS = 1000;
	localparam logic [6:0] WATCHDOG_TICKS = 7'(WATCHDOG_MS / TICK_MS);
endpackage : oed_pkg

// ==== oed_timer_if.sv ====
`timescale 1ns/1ps
interface oed_timer_if;
	logic tick;
	logic restart;
	logic wd_start;
	logic wd_kick;
	logic wd_expired;
	modport timer (output tick, output wd_expired, input restart, input wd_start, input wd_kick);
	modport ctrl (input tick, input wd_expired, output restart, output wd_start, output wd_kick);
endinterface : oed_timer_if

// ==== oed_tick_timer.sv ====
`timescale 1ns/1ps
module oed_tick_timer #(
	parameter int unsigned TICK_CYCLES = oed_pkg::TICK_CYCLES_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	oed_timer_if.timer tif
);
	typedef struct packed {
		logic [31:0] div_count;
		logic tick;
		logic [6:0] wd_count;
		logic wd_running;
		logic wd_expired;
	} oed_tick_state_type;

	oed_tick_state_type state;
	oed_tick_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		next_state.wd_expired = 1'b0;
		if (tif.restart) begin
			// Realigning the divider on each control write makes a count of N last exactly N ticks.
			next_state.div_count = 32'h00000000;
			next_state.wd_running = 1'b0;
		end else begin
			if (state.div_count == 32'(TICK_CYCLES - 1)) begin
				next_state.div_count = 32'h00000000;
				next_state.tick = 1'b1;
			end else begin
				next_state.div_count = state.div_count + 32'h00000001;
			end
			if (tif.wd_start) begin
				next_state.wd_count = oed_pkg::WATCHDOG_TICKS;
				next_state.wd_running = 1'b1;
			end else if (state.wd_running && tif.wd_kick) begin
				next_state.wd_count = oed_pkg::WATCHDOG_TICKS;
			end else if (state.wd_running && state.tick) begin
				if (state.wd_count == 7'h01) begin
					next_state.wd_running = 1'b0;
					next_state.wd_expired = 1'b1;
				end
				next_state.wd_count = state.wd_count - 7'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tif.tick = state.tick;
	assign tif.wd_expired = state.wd_expired;
endmodule : oed_tick_timer

// ==== oed_monitor.sv ====
`timescale 1ns/1ps
module oed_monitor #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_pointer,
	input wire logic reg_write,
	input wire logic [15:0] reg_write_data,
	input wire logic [15:0] reg_read_data,
	input wire logic link_addressed,
	input wire logic front_amp_sat_high,
	input wire logic front_amp_sat_low,
	input wire logic second_amp_sat_high,
	input wire logic second_amp_sat_low,
	input wire logic output_amp_common_mode,
	input wire logic neg_input_high,
	input wire logic neg_input_low,
	input wire logic pos_input_high,
	input wire logic pos_input_low,
	input wire logic converter_enable,
	input wire logic output_enable
);
	logic [8:0] fl;
	logic [11:0] dn;
	logic wr;
	logic seen;
	int cnt;
	assign fl = {front_amp_sat_high, front_amp_sat_low, second_amp_sat_high, second_amp_sat_low,
		output_amp_common_mode, neg_input_high, neg_input_low, pos_input_high, pos_input_low};
	assign wr = reg_write && reg_pointer == 5'h07;
	// Cycles since the last control write; far wider than any run needs.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 1'b0;
			cnt <= 0;
			dn <= 12'h000;
		end else begin
			seen <= seen || wr;
			cnt <= wr ? 0 : cnt + 1;
			dn <= wr ? reg_write_data[11:0] : dn;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_dly;
		seen |-> converter_enable == (dn[11:8] == 4'h0 || cnt > dn[11:8] * TICK_CYCLES);
	endproperty
	a_dly: assert property (p_dly) else $error("start delay wrong");
	property p_rise;
		$rose(converter_enable) |->
			cnt == (dn[11:8] == 4'h0 ? 0 : dn[11:8] * TICK_CYCLES + 1);
	endproperty
	a_rise: assert property (p_rise) else $error("start rise off");
	property p_oe;
		seen && cnt <= dn[7:0] * TICK_CYCLES + 1
			|-> output_enable == (dn[7:0] != 8'h00 && cnt <= dn[7:0] * TICK_CYCLES);
	endproperty
	a_oe: assert property (p_oe) else $error("output timer wrong");
	property p_kick; !output_enable && link_addressed && !wr |=> !output_enable; endproperty
	a_kick: assert property (p_kick) else $error("kick ignored");
	property p_idle; !seen |-> converter_enable && !output_enable; endproperty
	a_idle: assert property (p_idle) else $error("idle state wrong");
	property p_flt; reg_pointer == 5'h08 |=> reg_read_data == {7'h00, $past(fl)}; endproperty
	a_flt: assert property (p_flt) else $error("status wrong");
	property p_unm; !(reg_pointer inside {5'h07, 5'h08}) |=> reg_read_data == 16'h0000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	sequence s_wr; wr ##1 (reg_pointer == 5'h07 && !reg_write); endsequence
	property p_ctl; s_wr |=> reg_read_data == $past(reg_write_data, 2); endproperty
	a_ctl: assert property (p_ctl) else $error("readback wrong");
endmodule : oed_monitor
bind oed_output_enable_delay_timer oed_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.*);

// ==== oed_link_ctrl.sv ====
`timescale 1ns/1ps
module oed_link_ctrl (
	input wire logic sys_clk,
	input wire logic kick_en,
	output logic link_addressed = 1'b0
);
	int n = 0;
	// Addresses the device far more often than once a second, so expiry never races a kick.
	always @(posedge sys_clk) begin
		n <= kick_en && n < 50 ? n + 1 : 0;
		link_addressed <= kick_en && n == 50;
	end
endmodule : oed_link_ctrl

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, kick_en = 1'b0;
	logic [4:0] reg_pointer = 5'h00;
	logic [15:0] reg_write_data = 16'h0000, reg_read_data;
	logic [8:0] fl = 9'h000;
	logic link_addressed, converter_enable, output_enable;
	int miscompares = 0, compares = 0;
	oed_output_enable_delay_timer #(.TICK_CYCLES(4)) dut (.*, .front_amp_sat_high(fl[8]),
		.front_amp_sat_low(fl[7]), .second_amp_sat_high(fl[6]), .second_amp_sat_low(fl[5]),
		.output_amp_common_mode(fl[4]), .neg_input_high(fl[3]), .neg_input_low(fl[2]),
		.pos_input_high(fl[1]), .pos_input_low(fl[0]));
	oed_link_ctrl pal (.sys_clk(sys_clk), .kick_en(kick_en), .link_addressed(link_addressed));
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] p, input logic [15:0] v);
		@(posedge sys_clk);
		reg_pointer <= p;
		reg_write_data <= v;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] p, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_pointer <= p;
		repeat (2) @(posedge sys_clk);
		#1 chk("read", exp, reg_read_data);
	endtask : rd
	task automatic pins(input int c, input logic ce, oe);
		repeat (c) @(posedge sys_clk);
		#1 chk("enables", {14'h0, ce, oe}, {14'h0, converter_enable, output_enable});
	endtask : pins
	task automatic close_out;
		$display("counts %0d compares %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(5'h07, 16'h0000);
		pins(0, 1'b1, 1'b0);
		$display("test reset done");
		@(posedge sys_clk);
		kick_en <= 1'b1;
		wr(5'h07, 16'h0205);
		rd(5'h07, 16'h0205);
		pins(2, 1'b0, 1'b1);
		pins(6, 1'b1, 1'b1);
		pins(12, 1'b1, 1'b0);
		pins(600, 1'b1, 1'b0);
		@(posedge sys_clk);
		kick_en <= 1'b0;
		pins(500, 1'b1, 1'b1);
		$display("test countdown done");
		wr(5'h07, 16'h0F05);
		pins(3, 1'b0, 1'b1);
		wr(5'h07, 16'h0100);
		pins(2, 1'b0, 1'b0);
		pins(4, 1'b1, 1'b0);
		wr(5'h08, 16'hFFFF);
		rd(5'h07, 16'h0100);
		rd(5'h1F, 16'h0000);
		$display("test reload done");
		for (int i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			fl <= 9'h001 << i;
			rd(5'h08, 16'h0001 << i);
		end
		$display("test faults done");
		close_out();
	end
endmodule : tb
